// ==== hw/cnr_rx_port.sv ====
/*
  Receive port of the fast serial controller: octet-wide cells or nibbles
  from the PHY on the link clock, handed to the system clock domain.
  Assumes that in cell mode the PHY drives the data lines only while the receive enable is
  asserted toward it, and that nrst is held for several cycles of both clocks.
*/
// What this block does
// - Cell mode takes eight-bit octets in parallel, bit 7 most significant.
// - Each cell is 53 octets unless rx_soc starts the next one early; positions count 0 to 52.
// - Idle cells are accepted as ordinary cell slots.
// - Nibble modes take four-bit nibbles, input 3 most significant.
`timescale 1ns/100ps
module cnr_rx_port
  import cnr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               rx_run,
  input  wire logic               nibble_mode,
  input  wire logic               rx_link_clk,
  input  wire logic [OCTET_W-1:0] rx_data,
  input  wire logic               rx_soc,
  input  wire logic               rx_dv,
  output logic                    rx_enb_n,
  output logic                    out_valid,
  output logic [OCTET_W-1:0]      out_data,
  output logic [POS_W-1:0]        out_pos,
  output logic                    out_first,
  output logic                    out_nibble
);

  // ==========================================================================
  // Link domain reset and configuration synchronisers
  logic lrst_s1_reg;
  logic lrst_s2_reg;
  logic run_s1_reg;
  logic run_s2_reg;
  logic mode_s1_reg;
  logic mode_s2_reg;

  always_ff @(posedge rx_link_clk)
  begin
    lrst_s1_reg <= nrst;
    lrst_s2_reg <= lrst_s1_reg;
    run_s1_reg  <= rx_run;
    run_s2_reg  <= run_s1_reg;
    mode_s1_reg <= nibble_mode;
    mode_s2_reg <= mode_s1_reg;
  end

  // ==========================================================================
  // Link domain capture
  logic               enb_n_reg;
  logic               enb_n_next;
  logic [POS_W-1:0]   pos_reg;
  logic [POS_W-1:0]   pos_next;
  logic [OCTET_W-1:0] data_reg;
  logic [OCTET_W-1:0] data_next;
  logic               nib_reg;
  logic               nib_next;
  logic               octet_cap;
  logic               nib_cap;
  logic               send;
  logic               busy;

  function automatic logic [POS_W-1:0] next_pos(input logic [POS_W-1:0] p,
                                                input logic             soc);
    next_pos = (soc || p == LAST_POS) ? FIRST_POS : p + POS_STEP;
  endfunction

  always_comb
  begin
    // Data is valid in the same link cycle in which the enable is presented
    octet_cap  = ~mode_s2_reg & ~enb_n_reg & ~busy;
    // Nibbles are not throttled; one arriving while busy is lost
    nib_cap    = mode_s2_reg & run_s2_reg & rx_dv & ~busy;
    send       = octet_cap | nib_cap;
    pos_next   = pos_reg;
    data_next  = data_reg;
    nib_next   = nib_reg;
    if (octet_cap)
    begin
      pos_next  = next_pos(pos_reg, rx_soc);
      data_next = rx_data;
      nib_next  = 1'b0;
    end
    else if (nib_cap)
    begin
      data_next = {NIB_PAD, rx_data[NIBBLE_W-1:0]};
      nib_next  = 1'b1;
    end
    // Enable dropped while a word crosses; this is the only back-pressure
    enb_n_next = ~(run_s2_reg & ~mode_s2_reg & ~busy & ~send);
  end

  always_ff @(posedge rx_link_clk)
  begin
    if (!lrst_s2_reg)
    begin
      enb_n_reg <= 1'b1;
      pos_reg   <= LAST_POS;
      data_reg  <= DATA_RST;
      nib_reg   <= 1'b0;
    end
    else
    begin
      enb_n_reg <= enb_n_next;
      pos_reg   <= pos_next;
      data_reg  <= data_next;
      nib_reg   <= nib_next;
    end
  end

  assign rx_enb_n = enb_n_reg;

  // ==========================================================================
  // Crossing to the system clock
  logic [WORD_W-1:0] src_word;
  logic [WORD_W-1:0] dst_word;
  logic              dst_valid;
  logic [WORD_W-1:0] hold_reg;
  logic [WORD_W-1:0] hold_next;

  // Word is registered at send so it stays stable while busy
  always_comb
  begin
    src_word  = {nib_next, (pos_next == FIRST_POS) & ~nib_next, pos_next, data_next};
    hold_next = send ? src_word : hold_reg;
  end

  always_ff @(posedge rx_link_clk)
  begin
    if (!lrst_s2_reg)
    begin
      hold_reg <= WORD_RST;
    end
    else
    begin
      hold_reg <= hold_next;
    end
  end

  cnr_word_xfer u_xfer (
    .clk_src  (rx_link_clk),
    .nrst_src (lrst_s2_reg),
    .send     (send),
    .word     (hold_reg),
    .busy     (busy),
    .clk_dst  (clk),
    .nrst_dst (nrst),
    .valid    (dst_valid),
    .word_out (dst_word)
  );

  // ==========================================================================
  // System side outputs
  logic               valid_reg;
  logic               valid_next;
  logic [OCTET_W-1:0] odata_reg;
  logic [OCTET_W-1:0] odata_next;
  logic [POS_W-1:0]   opos_reg;
  logic [POS_W-1:0]   opos_next;
  logic               first_reg;
  logic               first_next;
  logic               onib_reg;
  logic               onib_next;

  always_comb
  begin
    valid_next = dst_valid;
    odata_next = odata_reg;
    opos_next  = opos_reg;
    first_next = first_reg;
    onib_next  = onib_reg;
    if (dst_valid)
    begin
      odata_next = dst_word[W_DATA_LSB +: OCTET_W];
      opos_next  = dst_word[W_POS_LSB +: POS_W];
      first_next = dst_word[W_FIRST_BIT];
      onib_next  = dst_word[W_NIB_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      valid_reg <= 1'b0;
      odata_reg <= DATA_RST;
      opos_reg  <= LAST_POS;
      first_reg <= 1'b0;
      onib_reg  <= 1'b0;
    end
    else
    begin
      valid_reg <= valid_next;
      odata_reg <= odata_next;
      opos_reg  <= opos_next;
      first_reg <= first_next;
      onib_reg  <= onib_next;
    end
  end

  assign out_valid  = valid_reg;
  assign out_data   = odata_reg;
  assign out_pos    = opos_reg;
  assign out_first  = first_reg;
  assign out_nibble = onib_reg;

  // ==========================================================================
  // Assertions
  property p_octet_data;
    @(posedge rx_link_clk) disable iff (!lrst_s2_reg)
    octet_cap |=> (data_reg == $past(rx_data)) && !nib_reg;
  endproperty
  a_octet_data: assert property (p_octet_data) else $error("octet not captured");

  property p_pos_range;
    @(posedge rx_link_clk) disable iff (!lrst_s2_reg)
    pos_reg <= LAST_POS;
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("cell position beyond 52");

  property p_pos_wrap;
    @(posedge rx_link_clk) disable iff (!lrst_s2_reg)
    (octet_cap && !rx_soc && pos_reg == LAST_POS) |=> pos_reg == FIRST_POS;
  endproperty
  a_pos_wrap: assert property (p_pos_wrap) else $error("cell did not wrap");

  property p_idle_slot;
    @(posedge rx_link_clk) disable iff (!lrst_s2_reg)
    (octet_cap && !rx_soc && pos_reg < LAST_POS) |=> pos_reg == $past(pos_reg) + POS_STEP;
  endproperty
  a_idle_slot: assert property (p_idle_slot) else $error("octet slot not counted");

  property p_enb_drop;
    @(posedge rx_link_clk) disable iff (!lrst_s2_reg)
    send |=> rx_enb_n [*2];
  endproperty
  a_enb_drop: assert property (p_enb_drop) else $error("enable held while busy");

  property p_nib_data;
    @(posedge rx_link_clk) disable iff (!lrst_s2_reg)
    nib_cap |=> data_reg == {NIB_PAD, $past(rx_data[NIBBLE_W-1:0])};
  endproperty
  a_nib_data: assert property (p_nib_data) else $error("nibble not captured");

  property p_mode_width;
    @(posedge rx_link_clk) disable iff (!lrst_s2_reg)
    // An enable already presented when the mode flips is withdrawn one edge later
    mode_s2_reg |-> !octet_cap ##1 rx_enb_n;
  endproperty
  a_mode_width: assert property (p_mode_width) else $error("octet taken in nibble mode");

  property p_out_pos;
    @(posedge clk) disable iff (!nrst)
    out_valid && out_first |-> out_pos == FIRST_POS && !out_nibble;
  endproperty
  a_out_pos: assert property (p_out_pos) else $error("first flag without position 0");

  c_wrap: cover property (@(posedge rx_link_clk) octet_cap && pos_reg == LAST_POS);
  c_nib: cover property (@(posedge rx_link_clk) nib_cap);
  c_first: cover property (@(posedge clk) out_valid && out_first);

endmodule // cnr_rx_port

// ==== hw/cnr_pkg.sv ====
/*
  Constants shared by the cell and nibble receive port.
  Assumes a system clock of 250 MHz and a link clock from the PHY side.
*/
package cnr_pkg;

  // ==========================================================================
  // Data widths
  localparam int          OCTET_W   = 8;
  localparam int          NIBBLE_W  = 4;
  localparam int          POS_W     = 6;
  localparam int          WORD_W    = 1 + 1 + POS_W + OCTET_W;

  // ==========================================================================
  // Cell geometry
  localparam logic [5:0]  CELL_OCTETS = 6'h35;
  localparam logic [5:0]  FIRST_POS   = 6'h00;
  localparam logic [5:0]  LAST_POS    = CELL_OCTETS - 6'h01;
  localparam logic [5:0]  POS_STEP    = 6'h01;

  // ==========================================================================
  // Word layout across the crossing
  localparam int          W_DATA_LSB  = 0;
  localparam int          W_POS_LSB   = 8;
  localparam int          W_FIRST_BIT = 14;
  localparam int          W_NIB_BIT   = 15;
  localparam logic [3:0]  NIB_PAD     = 4'h0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic [15:0] WORD_RST    = 16'h0000;

endpackage

// ==== hw/cnr_word_xfer.sv ====
/*
  Toggle handshake that carries one word from the link clock domain to the
  system clock domain. Assumes the source holds word stable while busy.
*/
`timescale 1ns/100ps
module cnr_word_xfer
  import cnr_pkg::*;
(
  input  wire logic              clk_src,
  input  wire logic              nrst_src,
  input  wire logic              send,
  input  wire logic [WORD_W-1:0] word,
  output logic                   busy,
  input  wire logic              clk_dst,
  input  wire logic              nrst_dst,
  output logic                   valid,
  output logic [WORD_W-1:0]      word_out
);

  // ==========================================================================
  // Source side
  logic req_reg;
  logic req_next;
  logic busy_reg;
  logic busy_next;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic ack_d_reg;

  always_comb
  begin
    req_next  = req_reg ^ (send & ~busy_reg);
    busy_next = (send & ~busy_reg) | (busy_reg & (ack_s2_reg != req_reg));
  end

  always_ff @(posedge clk_src)
  begin
    if (!nrst_src)
    begin
      req_reg    <= 1'b0;
      busy_reg   <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end
    else
    begin
      req_reg    <= req_next;
      busy_reg   <= busy_next;
      ack_s1_reg <= ack_d_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  assign busy = busy_reg;

  // ==========================================================================
  // Destination side
  // Word is captured only after the toggle has settled, so it is stable
  logic              req_s1_reg;
  logic              req_s2_reg;
  logic              ack_next;
  logic              valid_reg;
  logic              valid_next;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;

  always_comb
  begin
    valid_next = req_s2_reg != ack_d_reg;
    ack_next   = req_s2_reg;
    word_next  = valid_next ? word : word_reg;
  end

  always_ff @(posedge clk_dst)
  begin
    if (!nrst_dst)
    begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_d_reg  <= 1'b0;
      valid_reg  <= 1'b0;
      word_reg   <= WORD_RST;
    end
    else
    begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      ack_d_reg  <= ack_next;
      valid_reg  <= valid_next;
      word_reg   <= word_next;
    end
  end

  assign valid    = valid_reg;
  assign word_out = word_reg;

endmodule // cnr_word_xfer

// ==== testbench/cnr_phy_model.sv ====
/*
  Behavioural PHY for the receive port: one octet per receive enable in cell
  mode, or nibbles with rx_dv. Assumes a free-running link clock.
*/
`timescale 1ns/100ps
module cnr_phy_model
  import cnr_pkg::*;
(
  input  wire logic       lclk,
  input  wire logic       enb_n,
  input  wire logic       cell_on,
  input  wire logic       use_soc,
  input  wire logic       restart,
  input  wire logic       nib_on,
  output logic [7:0]      data,
  output logic            soc,
  output logic            dv,
  output logic [3:0]      nib
);
  logic [5:0] idx = 6'h00;
  logic [2:0] gap = 3'h0;
  initial
  begin
    data = 8'h5A;
    soc  = 1'b0;
    dv   = 1'b0;
    nib  = 4'hF;
  end
  // ==========================================================================
  // Drive just after the link edge and hold for the whole link cycle
  always @(posedge lclk)
  begin
    #1;
    gap  = gap + 3'h1;
    dv   = 1'b0;
    soc  = 1'b0;
    data = ~data;
    if (!enb_n && cell_on)
    begin
      if (restart)
        idx = FIRST_POS;
      data = {~idx[1:0], idx};
      soc  = use_soc && idx == FIRST_POS;
      idx  = (idx == LAST_POS) ? FIRST_POS : idx + POS_STEP;
    end
    // MII is not throttled, so nibbles come at a fixed slow pace
    if (nib_on && gap == 3'h0)
    begin
      nib  = nib + 4'h1;
      data = {~nib, nib};
      dv   = 1'b1;
    end
  end
endmodule // cnr_phy_model

// ==== testbench/cnr_rx_port_tb.sv ====
/*
  Self-checking bench for the receive port: cells, cell restart, wrap
  without start-of-cell, refusal and nibble mode. Assumes cnr_phy_model.
*/
`timescale 1ns/100ps
module cnr_rx_port_tb
  import cnr_pkg::*;
;
  logic       clk, lclk, nrst, rx_run, nibble_mode;
  logic       cell_on, use_soc, restart, nib_on;
  logic       rx_soc, rx_dv, rx_enb_n, out_valid, out_first, out_nibble;
  logic [7:0] rx_data, out_data;
  logic [5:0] out_pos, exp_pos;
  logic [3:0] nib;
  int         err_total = 0;
  int         compares  = 0;
  int         cyc       = 0;
  int         nvalid    = 0;

  cnr_rx_port DUT (.clk(clk), .nrst(nrst), .rx_run(rx_run), .nibble_mode(nibble_mode),
    .rx_link_clk(lclk), .rx_data(rx_data), .rx_soc(rx_soc), .rx_dv(rx_dv),
    .rx_enb_n(rx_enb_n), .out_valid(out_valid), .out_data(out_data), .out_pos(out_pos),
    .out_first(out_first), .out_nibble(out_nibble));
  cnr_phy_model phy (.lclk(lclk), .enb_n(rx_enb_n), .cell_on(cell_on), .use_soc(use_soc),
    .restart(restart), .nib_on(nib_on), .data(rx_data), .soc(rx_soc), .dv(rx_dv), .nib(nib));

  // ==========================================================================
  // Clocks and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #3;
    forever #6 lclk = ~lclk;
  end
  // Counted on the falling edge so the registered pulse has settled
  always @(negedge clk)
  begin
    cyc++;
    if (out_valid === 1'b1)
      nvalid++;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end

  // ==========================================================================
  // Shared tasks
  task end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task cmp1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [5:0] nxt(input logic [5:0] p);
    return (p == LAST_POS) ? FIRST_POS : p + POS_STEP;
  endfunction
  task automatic get_word;
    int n;
    n = 0;
    while (out_valid !== 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    if (n >= 300)
      cmp1(1'b0, 1'b1);
  endtask
  task chk_cell;
    get_word();
    cmp8({2'h0, out_pos}, {2'h0, exp_pos});
    cmp8(out_data, {~exp_pos[1:0], exp_pos});
    cmp1(out_first, exp_pos == FIRST_POS);
    cmp1(out_nibble, 1'b0);
    exp_pos = nxt(exp_pos);
    step(1);
  endtask
  // A word already in flight when the mode changes is allowed through
  task automatic quiet;
    int k, n0;
    n0 = nvalid;
    step(40);
    repeat (nvalid - n0) exp_pos = nxt(exp_pos);
    n0 = nvalid;
    k  = 0;
    repeat (60)
    begin
      step(1);
      if (rx_enb_n !== 1'b1)
        k++;
    end
    cmp8(8'(k), 8'h00);
    cmp8(8'(nvalid - n0), 8'h00);
  endtask

  // ==========================================================================
  // Scenarios
  task t_cells;
    repeat (60) chk_cell();
  endtask
  task t_restart;
    repeat (5) chk_cell();
    restart = 1'b1;
    exp_pos = FIRST_POS;
    chk_cell();
    restart = 1'b0;
  endtask
  task t_nosoc;
    use_soc = 1'b0;
    repeat (60) chk_cell();
    use_soc = 1'b1;
  endtask
  task t_stop;
    rx_run = 1'b0;
    quiet();
    rx_run = 1'b1;
    nibble_mode = 1'b1;
    quiet();
  endtask
  task t_nib;
    nib_on = 1'b1;
    repeat (4)
    begin
      get_word();
      cmp8(out_data, {4'h0, nib});
      cmp1(out_nibble, 1'b1);
      step(1);
    end
  endtask

  initial
  begin
    nrst        = 1'b0;
    rx_run      = 1'b1;
    nibble_mode = 1'b0;
    cell_on     = 1'b1;
    use_soc     = 1'b1;
    restart     = 1'b0;
    nib_on      = 1'b0;
    exp_pos     = FIRST_POS;
    // Long enough for several link edges as well
    step(12);
    cmp1(rx_enb_n, 1'b1);
    cmp1(out_valid, 1'b0);
    cmp8({2'h0, out_pos}, {2'h0, LAST_POS});
    nrst = 1'b1;
    t_cells();
    t_restart();
    t_nosoc();
    t_stop();
    t_nib();
    end_sim();
  end
endmodule // cnr_rx_port_tb
